//--- src/csfs_pkg.sv
// Shared constants and types for the core sequencer with flags and stack.
package csfs_pkg;
    localparam int PC_W = 13;
    localparam int PROG_BYTES = 8192;
    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] PC_STEP = 13'h0001;
    localparam int RAM_BYTES = 256;
    localparam logic [7:0] STACK_TOP = 8'hff;
    localparam int STACK_LEVEL_BYTES = 2;
    localparam int MAX_STACK_LEVELS = 128;
    localparam int IRB_COUNT = 20;
    localparam logic [4:0] IRB_SP = 5'h00;
    localparam logic [4:0] IRB_CMP_FIRST = 5'h01;
    localparam logic [4:0] IRB_CMP_LAST = 5'h0c;
    localparam logic [4:0] IRB_PORT_FIRST = 5'h0d;
    localparam logic [4:0] IRB_PORT_LAST = 5'h13;
    localparam int CMP_BYTES = 12;
    localparam int PORT_BYTES = 7;
    localparam int FLAG_DEPTH = 8;
    // Flag bit positions within a set.
    localparam int FLAG_C = 0;
    localparam int FLAG_Z = 1;
    localparam int FLAG_S = 2;
    localparam logic [2:0] FLAGS_RESET = 3'h0;

    typedef enum logic [4:0] {
        CSFS_GRP_LOAD = 5'b00001,
        CSFS_GRP_ALU = 5'b00010,
        CSFS_GRP_JUMP = 5'b00100,
        CSFS_GRP_CTRL = 5'b01000,
        CSFS_GRP_DEC = 5'b10000
    } csfs_grp_t;

    typedef enum logic [4:0] {
        CSFS_ST_FETCH = 5'b00001,
        CSFS_ST_EXEC = 5'b00010,
        CSFS_ST_PUSH_HI = 5'b00100,
        CSFS_ST_PUSH_LO = 5'b01000,
        CSFS_ST_POP = 5'b10000
    } csfs_state_t;
endpackage

//--- src/csfs_arbiter.sv
// One-hot decode-group arbiter and collector of group control words.
`timescale 1ns/1ns
`default_nettype none
module csfs_arbiter
    import csfs_pkg::*;
#(
    parameter int CTRL_W = 16
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Decoded instruction.
    input wire logic i_decode_valid,
    input wire logic [2:0] i_group_sel,
    input wire logic [5*CTRL_W-1:0] i_group_ctrl,
    // Collected outputs.
    output logic [4:0] o_group_active,
    output logic [CTRL_W-1:0] o_ctrl
);
    initial begin
        if (CTRL_W < 1) begin
            $error("CTRL_W must be positive");
        end
    end

    logic [4:0] next_active;
    logic [CTRL_W-1:0] next_ctrl;

    always_comb begin
        next_active = 5'h0;
        if (i_decode_valid && i_group_sel < 3'h5) begin
            next_active = 5'h1 << i_group_sel;
        end
        next_ctrl = '0;
        for (int g = 0; g < 5; g++) begin
            if (next_active[g]) begin
                next_ctrl = i_group_ctrl[g*CTRL_W +: CTRL_W];
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_group_active <= 5'h0;
            o_ctrl <= '0;
        end else begin
            o_group_active <= next_active;
            o_ctrl <= next_ctrl;
        end
    end

    a_one_group_only: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $onehot0(o_group_active))
        else $error("more than one decode group active");
endmodule // csfs_arbiter
`default_nettype wire

//--- src/csfs_flag_stack.sv
// Small memory holding saved flag sets across nested interrupts.
`timescale 1ns/1ns
`default_nettype none
module csfs_flag_stack
    import csfs_pkg::*;
#(
    parameter int DEPTH = FLAG_DEPTH
) (
    // Clock.
    input wire logic i_clk,
    // Write and read ports.
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [2:0] i_wdata,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr,
    output logic [2:0] o_rdata
);
    initial begin
        if (DEPTH < 2) begin
            $error("DEPTH must be at least 2");
        end
    end

    logic [2:0] mem [DEPTH];

    always_ff @(posedge i_clk) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rdata <= mem[i_raddr];
    end
endmodule // csfs_flag_stack
`default_nettype wire

//--- src/csfs_core.sv
// Core sequencer: program counter, flag sets, RAM stack and input bench.
`timescale 1ns/1ns
`default_nettype none
module csfs_core
    import csfs_pkg::*;
#(
    parameter int CTRL_W = 16,
    parameter int RAM_SIZE = RAM_BYTES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Program memory fetch.
    output logic [12:0] o_prog_addr,
    output logic o_prog_rd,
    input wire logic i_prog_ack,
    // Instruction decode results.
    input wire logic i_decode_valid,
    input wire logic [2:0] i_group_sel,
    input wire logic [5*CTRL_W-1:0] i_group_ctrl,
    input wire logic i_jump,
    input wire logic [12:0] i_jump_target,
    input wire logic i_call,
    input wire logic i_sub_exit,
    input wire logic i_int_exit,
    // Interrupt request.
    input wire logic i_int_take,
    input wire logic [12:0] i_int_vector,
    // Datapath flag update.
    input wire logic i_alu_update,
    input wire logic i_alu_arith,
    input wire logic i_alu_overflow,
    input wire logic i_alu_underflow,
    input wire logic [7:0] i_alu_result,
    // Load instruction access to RAM.
    input wire logic i_load_we,
    input wire logic [7:0] i_load_addr,
    input wire logic [7:0] i_load_wdata,
    input wire logic i_load_input,
    input wire logic [4:0] i_input_sel,
    output logic [7:0] o_load_rdata,
    // Peripheral bench inputs, same clock domain.
    input wire logic [8*CMP_BYTES-1:0] i_cmp_bytes,
    input wire logic [8*PORT_BYTES-1:0] i_port_bytes,
    // Control and status.
    output logic [4:0] o_group_active,
    output logic [CTRL_W-1:0] o_ctrl,
    output logic [2:0] o_flags,
    output logic o_int_mode,
    output logic [7:0] o_stack_pointer_view,
    output logic o_busy
);
    initial begin
        if (RAM_SIZE != 128 && RAM_SIZE != 256) begin
            $error("RAM_SIZE must be 128 or 256");
        end
    end

    csfs_state_t state;
    logic [12:0] pc;
    logic [7:0] sp;
    logic [7:0] ram [256];
    logic [2:0] flags_norm;
    logic [2:0] flags_int;
    logic int_mode;
    logic [2:0] fdepth;
    logic [12:0] push_val;
    logic [7:0] pop_hi;
    logic [2:0] fs_rdata;
    logic fs_we;
    logic [2:0] fs_wdata;
    logic [2:0] next_flags;
    logic [7:0] bench_byte;

    function automatic logic [12:0] csfs_inc(input logic [12:0] v);
        return v + PC_STEP;
    endfunction

    csfs_arbiter #(.CTRL_W(CTRL_W)) u_arb (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_decode_valid(i_decode_valid),
        .i_group_sel(i_group_sel),
        .i_group_ctrl(i_group_ctrl),
        .o_group_active(o_group_active),
        .o_ctrl(o_ctrl)
    );

    // The flag stack top is kept live so a return restores in one cycle.
    csfs_flag_stack #(.DEPTH(FLAG_DEPTH)) u_fstack (
        .i_clk(i_clk),
        .i_we(fs_we),
        .i_waddr(fdepth),
        .i_wdata(fs_wdata),
        .i_raddr(fdepth - 3'h1),
        .o_rdata(fs_rdata)
    );

    assign o_prog_addr = pc;
    assign o_prog_rd = (state == CSFS_ST_FETCH);
    assign o_busy = (state != CSFS_ST_FETCH);
    assign o_int_mode = int_mode;
    assign o_stack_pointer_view = sp;
    assign o_flags = int_mode ? flags_int : flags_norm;

    // Sequencer: fetch, execute, then stack pushes or pops as needed.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            state <= CSFS_ST_FETCH;
            pc <= RESET_VECTOR;
            push_val <= 13'h0;
        end else begin
            unique case (state)
                CSFS_ST_FETCH: begin
                    if (i_int_take) begin
                        push_val <= pc;
                        pc <= i_int_vector;
                        state <= CSFS_ST_PUSH_HI;
                    end else if (i_prog_ack) begin
                        pc <= csfs_inc(pc);
                        state <= CSFS_ST_EXEC;
                    end
                end
                CSFS_ST_EXEC: begin
                    if (!i_decode_valid) begin
                        state <= CSFS_ST_FETCH;
                    end else if (i_call) begin
                        push_val <= pc;
                        pc <= i_jump_target;
                        state <= CSFS_ST_PUSH_HI;
                    end else if (i_int_exit || i_sub_exit) begin
                        state <= CSFS_ST_POP;
                    end else begin
                        if (i_jump) begin
                            pc <= i_jump_target;
                        end
                        state <= CSFS_ST_FETCH;
                    end
                end
                CSFS_ST_PUSH_HI: state <= CSFS_ST_PUSH_LO;
                CSFS_ST_PUSH_LO: state <= CSFS_ST_FETCH;
                CSFS_ST_POP: begin
                    // Popped value from the top level reloads the counter.
                    pc <= {pop_hi[4:0], ram[sp - 8'h1]};
                    state <= CSFS_ST_FETCH;
                end
                default: state <= CSFS_ST_FETCH;
            endcase
        end
    end

    // Stack pointer names the next free byte, starting at the top of RAM.
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            sp <= STACK_TOP;
        end else if (state == CSFS_ST_PUSH_HI || state == CSFS_ST_PUSH_LO) begin
            sp <= sp - 8'h1;
        end else if (state == CSFS_ST_EXEC && i_decode_valid && !i_call
                     && (i_int_exit || i_sub_exit)) begin
            sp <= sp + 8'h2;
        end
    end

    // After a return sp names the high byte of the level being popped.
    assign pop_hi = ram[sp];

    // RAM has no reset; stack writes take priority over loads.
    always_ff @(posedge i_clk) begin
        if (state == CSFS_ST_PUSH_HI) begin
            ram[sp] <= {3'h0, push_val[12:8]};
        end else if (state == CSFS_ST_PUSH_LO) begin
            ram[sp] <= push_val[7:0];
        end else if (i_load_input) begin
            ram[i_load_addr] <= bench_byte;
        end else if (i_load_we) begin
            ram[i_load_addr] <= i_load_wdata;
        end
    end

    // Input bench is its own read-only space, separate from RAM.
    always_comb begin
        bench_byte = 8'h00;
        if (i_input_sel == IRB_SP) begin
            bench_byte = sp;
        end else if (i_input_sel <= IRB_CMP_LAST) begin
            bench_byte = i_cmp_bytes[8*(i_input_sel-IRB_CMP_FIRST) +: 8];
        end else if (i_input_sel <= IRB_PORT_LAST) begin
            bench_byte = i_port_bytes[8*(i_input_sel-IRB_PORT_FIRST) +: 8];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_load_rdata <= 8'h00;
        end else begin
            o_load_rdata <= ram[i_load_addr];
        end
    end

    // Flag result of the current operation.
    always_comb begin
        next_flags = o_flags;
        next_flags[FLAG_Z] = (i_alu_result == 8'h00);
        if (i_alu_arith) begin
            next_flags[FLAG_C] = i_alu_overflow;
            next_flags[FLAG_S] = i_alu_underflow;
        end
    end

    // Interrupt entry saves the active set; nothing is cleared on switch.
    assign fs_we = (state == CSFS_ST_FETCH) && i_int_take;
    assign fs_wdata = o_flags;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            flags_norm <= FLAGS_RESET;
            flags_int <= FLAGS_RESET;
            int_mode <= 1'b0;
            fdepth <= 3'h0;
        end else if (fs_we) begin
            if (int_mode) begin
                flags_int <= flags_int;
            end
            int_mode <= 1'b1;
            fdepth <= fdepth + 3'h1;
        end else if (state == CSFS_ST_EXEC && i_decode_valid && i_int_exit
                     && !i_call && fdepth != 3'h0) begin
            fdepth <= fdepth - 3'h1;
            if (fdepth == 3'h1) begin
                int_mode <= 1'b0;
            end else begin
                flags_int <= fs_rdata;
            end
        end else if (i_alu_update) begin
            if (int_mode) begin
                flags_int <= next_flags;
            end else begin
                flags_norm <= next_flags;
            end
        end
    end

    a_pc_inc_fetch: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        state == CSFS_ST_FETCH && i_prog_ack && !i_int_take
        |=> pc == $past(pc) + 13'h1)
        else $error("counter did not advance after fetch");

    a_pc_hold: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        state == CSFS_ST_FETCH && !i_prog_ack && !i_int_take
        |=> $stable(pc))
        else $error("counter moved without a fetch");

    a_int_vector: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        state == CSFS_ST_FETCH && i_int_take
        |=> pc == $past(i_int_vector) && int_mode)
        else $error("interrupt did not load vector or mode");

    a_jump_load: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        state == CSFS_ST_EXEC && i_decode_valid
        && (i_call || (i_jump && !i_int_exit && !i_sub_exit))
        |=> pc == $past(i_jump_target))
        else $error("jump or call target not loaded");

    sequence s_push;
        state == CSFS_ST_PUSH_HI ##1 state == CSFS_ST_PUSH_LO;
    endsequence

    a_stack_push: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        state == CSFS_ST_PUSH_HI |-> s_push ##1 sp == $past(sp, 2) - 8'h2)
        else $error("push did not use two bytes");

    // A return costs one pop cycle before the next fetch.
    sequence s_pop;
        state == CSFS_ST_POP ##1 state == CSFS_ST_FETCH;
    endsequence

    a_stack_pop: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        state == CSFS_ST_EXEC && i_decode_valid && !i_call
        && (i_int_exit || i_sub_exit)
        |=> (sp == $past(sp) + 8'h2) ##0 s_pop)
        else $error("return did not release one level");

    a_sp_reset: assert property (
        @(posedge i_clk)
        !i_rst_n |=> sp == 8'hff)
        else $error("stack pointer not at top after reset");

    a_norm_kept: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        int_mode |=> flags_norm == $past(flags_norm))
        else $error("normal flags changed in interrupt mode");

    a_entry_keeps: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fs_we |=> int_mode && flags_int == $past(flags_int)
        && flags_norm == $past(flags_norm))
        else $error("flags changed on interrupt entry");

    a_flag_save: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        fs_we |=> fdepth == $past(fdepth) + 3'h1)
        else $error("flag stack did not deepen on entry");

    a_exit_normal: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        state == CSFS_ST_EXEC && i_decode_valid && i_int_exit && !i_call
        && fdepth == 3'h1
        |=> !int_mode && flags_norm == $past(flags_norm))
        else $error("outermost return did not resume normal flags");

    a_zero_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_alu_update && !fs_we && state != CSFS_ST_EXEC
        |=> o_flags[1] == ($past(i_alu_result) == 8'h00))
        else $error("zero flag wrong");

    a_carry_flag: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_alu_update && i_alu_arith && !fs_we && state != CSFS_ST_EXEC
        && !int_mode |=> flags_norm[0] == $past(i_alu_overflow)
        && flags_norm[2] == $past(i_alu_underflow))
        else $error("carry or sign flag wrong");

    a_sp_view: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_load_input && i_input_sel == IRB_SP
        && state != CSFS_ST_PUSH_HI && state != CSFS_ST_PUSH_LO
        |=> ram[$past(i_load_addr)] == $past(sp))
        else $error("stack pointer copy to RAM wrong");
endmodule // csfs_core
`default_nettype wire

//--- testbench/csfs_core_tb_top.sv
// Self-checking bench for the core sequencer with flags and stack.
`timescale 1ns/1ns
`default_nettype none
module csfs_core_tb_top;
    import csfs_pkg::*;
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_prog_ack = 1'b0;
    logic i_decode_valid = 1'b0;
    logic [2:0] i_group_sel = 3'h0;
    logic [79:0] i_group_ctrl = '0;
    logic i_jump = 1'b0;
    logic [12:0] i_jump_target = 13'h0000;
    logic i_call = 1'b0;
    logic i_sub_exit = 1'b0;
    logic i_int_exit = 1'b0;
    logic i_int_take = 1'b0;
    logic [12:0] i_int_vector = 13'h0000;
    logic i_alu_update = 1'b0;
    logic i_alu_arith = 1'b0;
    logic i_alu_overflow = 1'b0;
    logic i_alu_underflow = 1'b0;
    logic [7:0] i_alu_result = 8'h00;
    logic i_load_we = 1'b0;
    logic [7:0] i_load_addr = 8'h00;
    logic [7:0] i_load_wdata = 8'h00;
    logic i_load_input = 1'b0;
    logic [4:0] i_input_sel = 5'h00;
    logic [95:0] i_cmp_bytes = '0;
    logic [55:0] i_port_bytes = '0;
    logic [12:0] o_prog_addr;
    logic o_prog_rd;
    logic [7:0] o_load_rdata;
    logic [4:0] o_group_active;
    logic [15:0] o_ctrl;
    logic [2:0] o_flags;
    logic o_int_mode;
    logic [7:0] o_stack_pointer_view;
    logic o_busy;
    int miscompares = 0;
    int n_checks = 0;
    // Reference state of the sequencer, kept in plain integers.
    int m_pc = 0;
    int m_sp = 255;
    int nf = 0;
    int intf = 0;
    int m_mode = 0;
    int ilev = 0;
    int ram [256];
    int stk [$];
    int fsv [$];

    csfs_core uut (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .o_prog_addr(o_prog_addr), .o_prog_rd(o_prog_rd),
        .i_prog_ack(i_prog_ack), .i_decode_valid(i_decode_valid),
        .i_group_sel(i_group_sel), .i_group_ctrl(i_group_ctrl),
        .i_jump(i_jump), .i_jump_target(i_jump_target), .i_call(i_call),
        .i_sub_exit(i_sub_exit), .i_int_exit(i_int_exit),
        .i_int_take(i_int_take), .i_int_vector(i_int_vector),
        .i_alu_update(i_alu_update), .i_alu_arith(i_alu_arith),
        .i_alu_overflow(i_alu_overflow), .i_alu_underflow(i_alu_underflow),
        .i_alu_result(i_alu_result), .i_load_we(i_load_we),
        .i_load_addr(i_load_addr), .i_load_wdata(i_load_wdata),
        .i_load_input(i_load_input), .i_input_sel(i_input_sel),
        .o_load_rdata(o_load_rdata), .i_cmp_bytes(i_cmp_bytes),
        .i_port_bytes(i_port_bytes), .o_group_active(o_group_active),
        .o_ctrl(o_ctrl), .o_flags(o_flags), .o_int_mode(o_int_mode),
        .o_stack_pointer_view(o_stack_pointer_view), .o_busy(o_busy));

    always #2 i_clk = ~i_clk;

    task automatic test_done();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wait_idle();
        int k;
        k = 0;
        while (o_busy !== 1'b0 && k < 20) begin
            @(negedge i_clk);
            k++;
        end
        if (o_busy !== 1'b0) begin
            miscompares++;
            $display("CHECK FAILED busy expected 0 seen %b", o_busy);
            test_done();
        end
    endtask

    task automatic chk_state();
        chk("pc", 16'(m_pc), 16'(o_prog_addr));
        chk("sp", 16'(m_sp), 16'(o_stack_pointer_view));
        chk("flags", 16'(m_mode ? intf : nf), 16'(o_flags));
        chk("mode", 16'(m_mode), 16'(o_int_mode));
    endtask

    task automatic rd(input int a, output logic [7:0] d);
        i_load_addr = 8'(a);
        @(negedge i_clk);
        d = o_load_rdata;
    endtask

    // Reads back the top level after a push, high byte above low byte.
    task automatic push(input int v);
        logic [7:0] d;
        ram[m_sp] = v >> 8;
        ram[m_sp - 1] = v & 255;
        stk.push_back(v);
        m_sp -= 2;
        wait_idle();
        rd(m_sp + 2, d);
        chk("stack_hi", 16'(ram[m_sp + 2]), 16'(d));
        rd(m_sp + 1, d);
        chk("stack_lo", 16'(ram[m_sp + 1]), 16'(d));
    endtask

    task automatic fetch();
        chk("prog_rd", 16'h0001, 16'(o_prog_rd));
        i_prog_ack = 1'b1;
        @(negedge i_clk);
        i_prog_ack = 1'b0;
        m_pc = (m_pc + 1) % PROG_BYTES;
        chk("pc_fetch", 16'(m_pc), 16'(o_prog_addr));
    endtask

    // Kinds: 0 plain, 1 jump, 2 call, 3 subroutine exit, 4 interrupt exit.
    task automatic exec(input int kind, input int sel);
        logic [12:0] tg;
        logic [79:0] cw;
        tg = 13'($urandom);
        cw = 80'({$urandom, $urandom, $urandom});
        i_decode_valid = 1'b1;
        i_group_sel = 3'(sel);
        i_group_ctrl = cw;
        i_jump_target = tg;
        i_jump = (kind == 1);
        i_call = (kind == 2);
        i_sub_exit = (kind == 3);
        i_int_exit = (kind == 4);
        @(negedge i_clk);
        {i_decode_valid, i_jump, i_call, i_sub_exit, i_int_exit} = '0;
        chk("group", 16'(5'h01 << sel), 16'(o_group_active));
        chk("ctrl", 16'(cw >> (16 * sel)), o_ctrl);
        if (kind == 1) begin
            m_pc = tg;
        end else if (kind == 2) begin
            push(m_pc);
            m_pc = tg;
        end else if (kind >= 3) begin
            m_sp += 2;
            m_pc = stk.pop_back();
            if (kind == 4) begin
                ilev--;
                if (ilev == 0) begin
                    m_mode = 0;
                    void'(fsv.pop_back());
                end else begin
                    intf = fsv.pop_back();
                end
            end
        end
        wait_idle();
        chk_state();
    endtask

    task automatic irq();
        logic [12:0] v;
        v = 13'($urandom);
        i_int_take = 1'b1;
        i_int_vector = v;
        @(negedge i_clk);
        i_int_take = 1'b0;
        fsv.push_back(m_mode ? intf : nf);
        ilev++;
        push(m_pc);
        m_mode = 1;
        m_pc = v;
        chk_state();
    endtask

    // Logic operations touch only zero; arithmetic also sets carry and sign.
    task automatic alu();
        logic [7:0] r;
        logic ov;
        logic un;
        logic ar;
        logic [2:0] cur;
        r = ($urandom % 3 == 0) ? 8'h00 : 8'($urandom);
        ov = 1'($urandom);
        un = 1'($urandom);
        ar = 1'($urandom);
        cur = 3'(m_mode ? intf : nf);
        i_alu_update = 1'b1;
        i_alu_arith = ar;
        i_alu_overflow = ov;
        i_alu_underflow = un;
        i_alu_result = r;
        @(negedge i_clk);
        i_alu_update = 1'b0;
        cur[FLAG_Z] = (r == 8'h00);
        if (ar) begin
            cur[FLAG_C] = ov;
            cur[FLAG_S] = un;
        end
        if (m_mode != 0) begin
            intf = int'(cur);
        end else begin
            nf = int'(cur);
        end
        chk("alu_c", 16'(cur[FLAG_C]), 16'(o_flags[FLAG_C]));
        chk("alu_s", 16'(cur[FLAG_S]), 16'(o_flags[FLAG_S]));
        chk("alu_z", 16'(r == 8'h00), 16'(o_flags[FLAG_Z]));
    endtask

    initial begin
        logic [7:0] d;
        logic [7:0] e;
        void'($urandom(32'hca93));
        i_cmp_bytes = {$urandom, $urandom, $urandom};
        i_port_bytes = 56'({$urandom, $urandom});
        repeat (8) @(negedge i_clk);
        i_rst_n = 1'b1;
        chk_state();
        chk("busy_rst", 16'h0000, 16'(o_busy));
        @(negedge i_clk);
        // Bench registers land in RAM well clear of the stack region.
        for (int s = 0; s < 22; s++) begin
            i_load_input = 1'b1;
            i_input_sel = 5'(s);
            i_load_addr = 8'(s + 16);
            @(negedge i_clk);
            i_load_input = 1'b0;
            if (s == 0) e = 8'(m_sp);
            else if (s < 13) e = i_cmp_bytes[8 * (s - 1) +: 8];
            else if (s < 20) e = i_port_bytes[8 * (s - 13) +: 8];
            else e = 8'h00;
            rd(s + 16, d);
            chk("bench", 16'(e), 16'(d));
        end
        i_load_we = 1'b1;
        i_load_addr = 8'h7f;
        i_load_wdata = 8'($urandom);
        @(negedge i_clk);
        i_load_we = 1'b0;
        rd(127, d);
        chk("ram", 16'(i_load_wdata), 16'(d));
        // Decode inputs outside the execute state must not move the pc.
        i_decode_valid = 1'b1;
        i_jump = 1'b1;
        i_jump_target = 13'h1fff;
        @(negedge i_clk);
        {i_decode_valid, i_jump} = '0;
        chk_state();
        for (int k = 0; k < 5; k++) begin
            fetch();
            exec(0, k);
        end
        fetch();
        exec(1, 2);
        alu();
        for (int k = 0; k < 3; k++) begin
            fetch();
            exec(2, 3);
            alu();
        end
        for (int k = 0; k < 3; k++) begin
            fetch();
            exec(3, 3);
        end
        alu();
        irq();
        alu();
        irq();
        alu();
        fetch();
        exec(4, 3);
        fetch();
        exec(4, 3);
        alu();
        irq();
        fetch();
        exec(4, 3);
        // A reset in mid-run, taken inside an interrupt, restarts everything but the RAM and flag stack memory contents.
        irq();
        i_rst_n = 1'b0;
        repeat (2) @(negedge i_clk);
        i_rst_n = 1'b1;
        m_pc = 0;
        m_sp = 255;
        nf = 0;
        intf = 0;
        m_mode = 0;
        ilev = 0;
        stk.delete();
        fsv.delete();
        chk_state();
        fetch();
        exec(0, 4);
        test_done();
    end

    initial begin
        repeat (50000) @(posedge i_clk);
        miscompares++;
        $display("CHECK FAILED run_length expected end seen timeout");
        test_done();
    end
endmodule // csfs_core_tb_top
`default_nettype wire
